// >>> design/fdso_top.sv
// drive-side index, home track, protect, read data and motor logic
`include "fdso_map.svh"

module fdso_top
  import fdso_pkg::*;
#(
  parameter int unsigned REV_CYC   = `FDSO_REV_CYC,
  parameter int unsigned INDEX_CYC = `FDSO_INDEX_CYC
) (
  // clock and reset
  input  wire logic   clock_i,
  input  wire logic   srst_i,
  // controller side inputs
  input  wire logic   select_n_i,
  input  wire logic   write_enable_n_i,
  input  wire logic   motor_on_n_i,
  // mechanism side inputs
  input  wire logic   home_switch_i,
  input  wire logic [1:0] step_phase_i,
  input  wire logic   media_protect_i,
  input  wire logic   flux_level_i,
  // controller side outputs
  output fdso_status_t status_o,
  // mechanism side outputs
  output logic        write_allow_o,
  output logic        spindle_on_o,
  output logic        rev_tick_o
);

  localparam int unsigned RD_CYC = `FDSO_RD_CYC;

  logic [31:0]  rev_cnt;
  logic [15:0]  deb_cnt;
  logic         home_deb;
  logic         flux_q;
  logic [7:0]   run_len;
  logic [7:0]   rd_cnt;
  fdso_spin_t   spin;
  fdso_status_t next_status;

  wire selected   = ~select_n_i;
  wire read_state = write_enable_n_i;
  wire index_win  = (rev_cnt < INDEX_CYC) && (spin == FDSO_SP_RUN);
  wire at_phase0  = (step_phase_i == `FDSO_PHASE_HOME);
  wire flux_edge  = flux_level_i ^ flux_q;
  // a transition is kept only if the previous level lasted long enough
  wire flux_ok    = flux_edge && (run_len >= `FDSO_FLUX_MIN_CYC);
  wire rd_active  = (rd_cnt != 8'h00);

  // spindle state follows motor on; speed loop is analog, outside here
  always_ff @(posedge clock_i) begin
    if (srst_i) spin <= FDSO_SP_STOP;
    else spin <= motor_on_n_i ? FDSO_SP_STOP : FDSO_SP_RUN;
  end
  assign spindle_on_o = (spin == FDSO_SP_RUN);

  // revolution timer; index window is its first INDEX_CYC cycles
  always_ff @(posedge clock_i) begin
    if (srst_i || spin != FDSO_SP_RUN) rev_cnt <= '0;
    else if (rev_cnt == REV_CYC - 1) rev_cnt <= '0;
    else rev_cnt <= rev_cnt + 32'd1;
  end
  assign rev_tick_o = (spin == FDSO_SP_RUN) && (rev_cnt == 32'd0);

  // switch debounce: level accepted after a stable run
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      deb_cnt  <= '0;
      home_deb <= 1'b0;
    end else if (home_switch_i == home_deb) begin
      deb_cnt <= '0;
    end else if (deb_cnt == `FDSO_DEB_CYC) begin
      home_deb <= home_switch_i;
      deb_cnt  <= '0;
    end else begin
      deb_cnt <= deb_cnt + 16'h0001;
    end
  end

  // flux run length and 1 us read pulse shaper
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flux_q  <= 1'b0;
      run_len <= '0;
      rd_cnt  <= '0;
    end else begin
      flux_q  <= flux_level_i;
      run_len <= flux_edge ? 8'h00 :
                 (run_len == 8'hff ? run_len : run_len + 8'h01);
      if (!read_state) rd_cnt <= '0;
      else if (flux_ok) rd_cnt <= RD_CYC[7:0];
      else if (rd_active) rd_cnt <= rd_cnt - 8'h01;
    end
  end

  // select gating of every status pin
  always_comb begin
    next_status.index_n      = ~(selected && index_win);
    next_status.home_track_n = ~(selected && home_deb
                                 && at_phase0);
    next_status.protect_n    = ~(selected && media_protect_i);
    next_status.read_data_n  = ~(selected && (rd_active || flux_ok)
                                 && read_state);
  end

  // registered pins; reset drives all high
  always_ff @(posedge clock_i) begin
    if (srst_i) status_o <= '1;
    else status_o <= next_status;
  end

  // protection overrides write enable
  assign write_allow_o = selected && !write_enable_n_i
                         && !media_protect_i;

  // index stays low for at least one more clock after it falls at a selected drive
  index_width_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $fell(status_o.index_n) && selected |=> status_o.index_n == 1'b0)
    else $error("index pulse too short");

  deselect_high_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(select_n_i) |-> status_o == '1)
    else $error("status low while deselected");

  home_qual_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    !status_o.home_track_n |-> $past(home_deb && at_phase0))
    else $error("home track without phase zero");

  home_set_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    selected && home_deb && at_phase0 |=> !status_o.home_track_n)
    else $error("home track not asserted");

  protect_block_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    media_protect_i |-> !write_allow_o)
    else $error("write allowed on protected media");

  protect_pin_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    selected && media_protect_i |=> !status_o.protect_n)
    else $error("protect pin not low");

  sequence rd_start_s;
    selected && read_state && flux_ok;
  endsequence
  read_pulse_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    rd_start_s ##1 (selected && read_state && !flux_edge)[*4]
      |=> !status_o.read_data_n)
    else $error("read pulse ended early");

  write_quiet_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    !$past(write_enable_n_i) |-> status_o.read_data_n)
    else $error("read pulse during write");

  glitch_drop_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    flux_edge && run_len < `FDSO_FLUX_MIN_CYC && !rd_active
      |=> status_o.read_data_n)
    else $error("short glitch produced pulse");

  rev_wrap_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    spin == FDSO_SP_RUN && rev_cnt == REV_CYC - 1 && !motor_on_n_i
      |=> rev_cnt == 32'd0)
    else $error("revolution timer did not wrap");

  // reset leaves every status pin idle and the spindle stopped;
  // no disable here, since reset itself is what is watched
  reset_idle_a: assert property (
    @(posedge clock_i)
    $past(srst_i) |-> status_o == '1 && !spindle_on_o)
    else $error("status active right after reset");

  // the spindle command follows motor on with one clock of delay
  spin_follow_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    !motor_on_n_i |=> spindle_on_o)
    else $error("spindle not started");

  // each revolution start opens an index pulse at a selected drive
  sequence rev_start_s;
    rev_tick_o && selected;
  endsequence
  index_start_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    rev_start_s |=> !status_o.index_n)
    else $error("index missing at revolution start");

  // debounced level may only move after a full stable count
  home_deb_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $changed(home_deb) |-> $past(deb_cnt) == `FDSO_DEB_CYC)
    else $error("home switch accepted without debounce");

  // leaving the home track releases the pin on the next clock
  sequence home_off_s;
    selected && !home_deb;
  endsequence
  home_drop_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    home_off_s |=> status_o.home_track_n)
    else $error("home track held off track");

  // read pulses reach the pin only while selected
  read_gate_a: assert property (
    @(posedge clock_i) disable iff (srst_i)
    !selected |=> status_o.read_data_n)
    else $error("read pulse while deselected");

endmodule // fdso_top

// >>> design/fdso_map.svh
// constants for the disk drive status output block
`ifndef FDSO_MAP_SVH
`define FDSO_MAP_SVH
`define FDSO_CLK_MHZ        200
`define FDSO_REV_US         200000
`define FDSO_INDEX_US       4000
`define FDSO_RD_PULSE_NS    1000
`define FDSO_CLK_NS         5
`define FDSO_REV_CYC        (`FDSO_REV_US * `FDSO_CLK_MHZ)
`define FDSO_INDEX_CYC      (`FDSO_INDEX_US * `FDSO_CLK_MHZ)
`define FDSO_RD_CYC         (`FDSO_RD_PULSE_NS / `FDSO_CLK_NS)
`define FDSO_DEB_CYC        16'h0fa0
`define FDSO_RPM            300
`define FDSO_RPM_TOL_PERMIL 15
`define FDSO_FLUX_MIN_CYC   8'h04
`define FDSO_PHASE_HOME     2'h0
`endif

// >>> design/fdso_pkg.sv
// types for the disk drive status output block
package fdso_pkg;
  // drive-side status pins, all active low
  typedef struct packed {
    logic index_n;
    logic home_track_n;
    logic protect_n;
    logic read_data_n;
  } fdso_status_t;

  typedef enum logic [1:0] {
    FDSO_SP_STOP = 2'b00,
    FDSO_SP_RUN  = 2'b01
  } fdso_spin_t;
endpackage

// >>> sim/fdso_ctrl_model.sv
// controller-side model driving select, write enable and motor lines
module fdso_ctrl_model
  import fdso_pkg::*;
(
  // clock
  input  wire logic   clock_i,
  // bench requests
  input  wire logic   want_sel_i,
  input  wire logic   want_wr_i,
  input  wire logic   want_mot_i,
  // drive status
  input  fdso_status_t status_i,
  // drive control lines, then index and read leading edge strobes
  output logic        select_n_o,
  output logic        write_enable_n_o,
  output logic        motor_on_n_o,
  output logic        index_fall_o,
  output logic        read_fall_o
);
  logic idx_q;
  logic rd_q;
  // a write never starts while protected, one in progress may run on
  always_ff @(posedge clock_i) begin
    select_n_o       <= ~want_sel_i;
    write_enable_n_o <= ~want_wr_i
                        | (write_enable_n_o & ~status_i.protect_n);
    motor_on_n_o     <= ~want_mot_i;
    idx_q            <= status_i.index_n;
    rd_q             <= status_i.read_data_n;
  end
  // track start is the falling edge, never the trailing one
  assign index_fall_o = idx_q & ~status_i.index_n;
  // flux position is the read pulse leading edge
  assign read_fall_o  = rd_q & ~status_i.read_data_n;
endmodule // fdso_ctrl_model

// >>> sim/test_fdso_top.sv
// bench for the drive status outputs with a controller model
module test_fdso_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fdso_pkg::*;
  logic clock_i = 0, srst_i = 1, sel = 0, wr = 0, mot = 0;
  logic sw = 0, prot = 0, flux = 0;
  logic [1:0] ph = 2'h0;
  logic sel_n, we_n, mot_n, allow, spin, tick, idx_fall, rd_fall;
  fdso_status_t status_o;
  int n_fail = 0, samples_checked = 0, cyc = 0, lows, edges;
  int ticks, redges;
  initial forever #2.5 clock_i = ~clock_i;
  fdso_ctrl_model u_fdso_ctrl_model (.clock_i, .want_sel_i(sel),
    .want_wr_i(wr), .want_mot_i(mot), .status_i(status_o),
    .select_n_o(sel_n), .write_enable_n_o(we_n), .motor_on_n_o(mot_n),
    .index_fall_o(idx_fall), .read_fall_o(rd_fall));
  // short revolution so the run stays brief
  fdso_top #(.REV_CYC(2000), .INDEX_CYC(40)) u_fdso_top (.clock_i,
    .srst_i, .select_n_i(sel_n), .write_enable_n_i(we_n),
    .motor_on_n_i(mot_n), .home_switch_i(sw), .step_phase_i(ph),
    .media_protect_i(prot), .flux_level_i(flux), .status_o,
    .write_allow_o(allow), .spindle_on_o(spin), .rev_tick_o(tick));
  task automatic go(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // samples off the edge so updates have landed
  task automatic check(input logic [31:0] got, exp);
    #1;
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // low cycles of one status bit and index leading edges
  task automatic watch(input int n, b);
    lows = 0;
    edges = 0;
    ticks = 0;
    redges = 0;
    repeat (n) begin
      @(posedge clock_i);
      #1;
      lows += (status_o[b] === 1'b0);
      edges += (idx_fall === 1'b1);
      ticks += (tick === 1'b1);
      redges += (rd_fall === 1'b1);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_index;
    go(1);
    mot <= 1'b1;
    watch(2100, 3);
    check(lows, 0);
    go(1);
    sel <= 1'b1;
    watch(4000, 3);
    check(lows, 80);
    check(edges, 2);
    check(ticks, 2);
    check(spin, 1'b1);
    go(1);
    mot <= 1'b0;
    go(3);
    check(spin, 1'b0);
    $display("index test done");
  endtask
  task automatic t_home;
    go(1);
    sw <= 1'b1;
    go(10);
    sw <= 1'b0;
    watch(4100, 2);
    check(lows, 0);
    go(1);
    sw <= 1'b1;
    watch(4100, 2);
    check(status_o[2], 1'b0);
    go(1);
    ph <= 2'h1;
    go(3);
    check(status_o[2], 1'b1);
    go(1);
    ph <= 2'h0;
    sel <= 1'b0;
    go(4);
    check(status_o, 4'hf);
    $display("home test done");
  endtask
  task automatic t_protect;
    go(1);
    sel <= 1'b1;
    wr <= 1'b1;
    go(3);
    check(allow, 1'b1);
    go(1);
    prot <= 1'b1;
    go(3);
    check({status_o[1], allow}, 2'b00);
    go(1);
    prot <= 1'b0;
    wr <= 1'b0;
    $display("protect test done");
  endtask
  task automatic t_read;
    go(4);
    flux <= 1'b1;
    watch(300, 0);
    check(lows, 201);
    check(redges, 1);
    go(1);
    flux <= 1'b0;
    go(2);
    flux <= 1'b1;
    watch(300, 0);
    check(lows, 199);
    check(redges, 0);
    go(1);
    wr <= 1'b1;
    go(3);
    flux <= 1'b0;
    watch(300, 0);
    check(lows, 0);
    $display("read test done");
  endtask
  initial begin
    go(10);
    srst_i <= 1'b0;
    check(status_o, 4'hf);
    t_index();
    t_home();
    t_protect();
    t_read();
    complete_run();
  end
  // hang guard well above the expected run of about 15260 cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end
endmodule // test_fdso_top
